// ### core/nfh_pkg.sv
/*
 * Package for the NAND flash host sequencer: command codes, host register
 *   offsets, field positions, pin timing counts and state enumerations.
 * Assumes a 10 MHz system clock; the flash device sits outside on pins.
 */
package nfh_pkg;
  // Flash command codes
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_RAND_INPUT   = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;
  localparam logic [7:0] CMD_RESET        = 8'hFF;
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_SIGNATURE    = 8'h90;
  localparam logic [7:0] SIG_ADDR         = 8'h00;
  // Page geometry
  localparam int unsigned PAGE_BYTES   = 2112;
  localparam int unsigned FULL_ADDR_CY = 5;
  localparam int unsigned COL_ADDR_CY  = 2;
  localparam int unsigned ROW_ADDR_CY  = 3;
  localparam int unsigned SIG_BYTES    = 4;
  // Status register bit positions
  localparam int unsigned STS_PROTECT = 7;
  localparam int unsigned STS_READY   = 6;
  localparam int unsigned STS_IDLE    = 5;
  localparam int unsigned STS_FAIL    = 0;
  // Signature byte 3 fields
  localparam int unsigned SIG3_DIE_LSB   = 0;
  localparam int unsigned SIG3_LEVEL_LSB = 2;
  localparam int unsigned SIG3_PAGES_LSB = 4;
  // Host register offsets (word index on the software port)
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_COLUMN   = 4'h1;
  localparam logic [3:0] REG_ROW      = 4'h2;
  localparam logic [3:0] REG_COUNT    = 4'h3;
  localparam logic [3:0] REG_WDATA    = 4'h4;
  localparam logic [3:0] REG_STATE    = 4'h5;
  localparam logic [3:0] REG_STATUS   = 4'h6;
  localparam logic [3:0] REG_SIG      = 4'h7;
  localparam logic [3:0] REG_RCOLUMN  = 4'h8;
  // Control register opcodes (bits 2:0 of a write to REG_CTRL)
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_ERASE   = 3'h2;
  localparam logic [2:0] OP_RESET   = 3'h3;
  localparam logic [2:0] OP_STATUS  = 3'h4;
  localparam logic [2:0] OP_SIG     = 3'h5;
  localparam logic [2:0] OP_RANDIN  = 3'h6;
  // Pin timing: strobe low and high phases at 10 MHz
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned STROBE_NS    = 100;
  localparam int unsigned STROBE_CY    =
    (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] ZERO8 = 8'h00;

  typedef enum logic [1:0] {
    NFH_CYC_CMD, NFH_CYC_ADDR, NFH_CYC_DATA, NFH_CYC_READ
  } nfh_cycle_t;

  typedef enum logic [3:0] {
    NFH_IDLE, NFH_P_SETUP, NFH_P_ADDR, NFH_P_DATA, NFH_P_CONF, NFH_WAIT_RB,
    NFH_E_SETUP, NFH_E_ADDR, NFH_E_CONF, NFH_STAT_CMD, NFH_STAT_RD,
    NFH_SIG_CMD, NFH_SIG_ADDR, NFH_SIG_RD, NFH_RST_CMD, NFH_R_ADDR
  } nfh_state_t;
endpackage : nfh_pkg

// ### core/nfh_cycle_if.sv
/*
 * Interface between the host sequencer and its pin cycle engine.
 * Assumes both ends share clk_sys_in.
 */
`timescale 1ns/100ps
interface nfh_cycle_if;
  import nfh_pkg::*;
  logic       start;  // One-cycle request
  nfh_cycle_t kind;   // Command, address, data write or data read
  logic [7:0] wdata;  // Byte to drive
  logic       done;   // One-cycle completion pulse
  logic [7:0] rdata;  // Byte captured on a read cycle
  modport seq (output start, kind, wdata, input done, rdata);
  modport eng (input start, kind, wdata, output done, rdata);
endinterface : nfh_cycle_if

// ### core/nfh_pin_engine.sv
/*
 * Pin cycle engine: runs one bus cycle on the flash pins per request.
 * Assumes io_in is already synchronised by the top module.
 */
`timescale 1ns/100ps
module nfh_pin_engine
  import nfh_pkg::*;
(
  input  wire logic  clk_sys_in,    // System clock
  input  wire logic  rst_n,         // Synchronised reset
  nfh_cycle_if.eng   cyc,           // Request port
  input  wire logic [7:0] io_in,    // Synchronised data pins
  output logic [7:0] io_out,        // Data pin drive value
  output logic       io_oe,         // Data pin enable
  output logic       cmd_latch,     // command_latch_select
  output logic       addr_latch,    // address_latch_select
  output logic       wr_n,          // Write strobe
  output logic       rd_n           // Read strobe
);
  localparam logic [3:0] PHASE_CY = 4'(STROBE_CY);
  logic [3:0] cnt;     // Phase counter
  logic [1:0] phase;   // 0 idle, 1 strobe low, 2 strobe high
  nfh_cycle_t kind_q;  // Latched request kind

  // Cycle sequencing: strobe low for a phase, then high for a phase
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0; cnt <= 4'h0; kind_q <= NFH_CYC_CMD;
      io_out <= 8'h00; io_oe <= 1'b0; cmd_latch <= 1'b0;
      addr_latch <= 1'b0; wr_n <= 1'b1; rd_n <= 1'b1;
      cyc.done <= 1'b0; cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      unique case (phase)
        2'h0: if (cyc.start) begin
          kind_q     <= cyc.kind;
          io_out     <= cyc.wdata;
          io_oe      <= (cyc.kind != NFH_CYC_READ);
          cmd_latch  <= (cyc.kind == NFH_CYC_CMD);
          addr_latch <= (cyc.kind == NFH_CYC_ADDR);
          wr_n       <= (cyc.kind == NFH_CYC_READ);
          rd_n       <= (cyc.kind != NFH_CYC_READ);
          cnt <= PHASE_CY; phase <= 2'h1;
        end
        2'h1: if (cnt > 4'h1) cnt <= cnt - 4'h1;
        else begin
          // Device latches on the write strobe rising edge
          wr_n <= 1'b1; rd_n <= 1'b1;
          if (kind_q == NFH_CYC_READ) cyc.rdata <= io_in;
          cnt <= PHASE_CY; phase <= 2'h2;
        end
        default: if (cnt > 4'h1) cnt <= cnt - 4'h1;
        else begin
          // Hold data past the edge, then release the latches
          io_oe <= 1'b0; cmd_latch <= 1'b0; addr_latch <= 1'b0;
          cyc.done <= 1'b1; phase <= 2'h0;
        end
      endcase
    end
  end

  strobe_pairing_a: assert property (@(posedge clk_sys_in) disable iff
    (!rst_n) !(wr_n == 1'b0 && rd_n == 1'b0))
    else $error("Both strobes low");
endmodule : nfh_pin_engine

// ### core/nfh_host.sv
/*
 * Host sequencer for a multi-level NAND flash: page program with random
 *   column input, block erase, reset, status polling and signature read.
 * Assumes a flash on the multiplexed 8-bit bus with an open-drain
 *   ready/busy line; software drives the plain register port.
 */
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
// Behaviour
// - Each page programmed once before erase; only the row of the last program is refused, and any erase clears it
// - Sequential load stays in one block
// - Setup, five addresses, data, confirm order
// - Random input: 85h plus two column cycles
// - Erase: setup, three row cycles, confirm
// - Fresh read command after status mid-read
// - Signature: 90h, address 00h, four reads
// - Full address: two column, three row
module nfh_host
  import nfh_pkg::*;
#(
  parameter int unsigned PAGE_MAX = PAGE_BYTES  // Bytes per program op
) (
  input  wire logic        clk_sys_in,      // 10 MHz system clock
  input  wire logic        reset_n_in,      // Asynchronous reset
  input  wire logic [3:0]  reg_addr_in,     // Register index
  input  wire logic [31:0] reg_wdata_in,    // Write data
  input  wire logic        reg_wr_in,       // Write strobe
  input  wire logic        reg_rd_in,       // Read strobe
  output logic      [31:0] reg_rdata_out,   // Read data, next cycle
  input  wire logic [7:0]  flash_io_in,     // Data pins, as seen
  output logic      [7:0]  flash_io_out,    // Data pins, drive value
  output logic             flash_io_oe_out, // Data pins, enable
  output logic             command_latch_select_out,
  output logic             address_latch_select_out,
  output logic             flash_chip_sel_n_out,
  output logic             flash_wr_n_out,
  output logic             flash_rd_n_out,
  output logic             flash_wp_n_out,  // Write protect drive
  input  wire logic        flash_rb_in      // Ready/busy, high ready
);
  logic       rst_meta, rst_n;          // Reset release chain
  logic [7:0] io_m, io_s;               // Data pin synchroniser
  logic       rb_m, rb_s;               // Ready/busy synchroniser
  nfh_cycle_if cyc ();                  // Link to pin engine
  nfh_state_t state;                    // Sequencer state
  logic [11:0] column, rcolumn;         // Column address, random column
  logic [17:0] row;                     // Page and block address
  logic [11:0] count;                   // Bytes to load, minus one
  logic [11:0] loaded;                  // Bytes loaded so far, stopping at count
  logic [7:0]  wbyte;                   // Next program byte
  logic        wbyte_vld;               // Software has supplied wbyte
  logic        rand_req;                // Random column input pending
  logic [2:0]  idx;                     // Address or signature index
  logic [7:0]  status;                  // Last status byte
  logic [31:0] sig;                     // Four signature bytes
  logic        wp_n;                    // Write protect enable
  logic        busy;                    // Sequencer busy
  logic        refused;                 // Last request refused
  logic        issue;                   // Start a pin cycle this clock
  logic        awaiting;                // A pin cycle is in flight
  logic [17:0] last_row;                // Row of the last program
  logic        last_vld;                // No erase since that program

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0; rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1; rst_n <= rst_meta;
    end
  end

  // Pin inputs cross into the clock domain before any use
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      io_m <= 8'h00; io_s <= 8'h00; rb_m <= 1'b0; rb_s <= 1'b0;
    end else begin
      io_m <= flash_io_in; io_s <= io_m;
      rb_m <= flash_rb_in; rb_s <= rb_m;
    end
  end

  nfh_pin_engine u_eng (
    .clk_sys_in (clk_sys_in),
    .rst_n      (rst_n),
    .cyc        (cyc.eng),
    .io_in      (io_s),
    .io_out     (flash_io_out),
    .io_oe      (flash_io_oe_out),
    .cmd_latch  (command_latch_select_out),
    .addr_latch (address_latch_select_out),
    .wr_n       (flash_wr_n_out),
    .rd_n       (flash_rd_n_out)
  );

  // Chip select held low once out of reset; the device is alone on the bus
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      flash_chip_sel_n_out <= 1'b1;
      flash_wp_n_out       <= 1'b0;
    end else begin
      flash_chip_sel_n_out <= 1'b0;
      flash_wp_n_out       <= wp_n;
    end
  end

  // Address byte for cycle idx: two column then three row cycles
  function automatic logic [7:0] addr_byte(input logic [2:0] i,
      input logic [11:0] c, input logic [17:0] r);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      3'h0: b = c[7:0];
      3'h1: b = {4'h0, c[11:8]};
      3'h2: b = r[7:0];
      3'h3: b = r[15:8];
      default: b = {6'h00, r[17:16]};
    endcase
    return b;
  endfunction : addr_byte

  assign busy  = (state != NFH_IDLE);
  // Waiting for ready runs no pin cycle, so the ready exit can be reached
  assign issue = busy && state != NFH_WAIT_RB && !cyc.start && !awaiting;

  // Sequencer: walks one operation through its pin cycles
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= NFH_IDLE; idx <= 3'h0; loaded <= 12'h000;
      cyc.start <= 1'b0; cyc.kind <= NFH_CYC_CMD; cyc.wdata <= 8'h00;
      awaiting <= 1'b0; status <= 8'h00; sig <= 32'h0; refused <= 1'b0;
      last_row <= 18'h00000;
      last_vld <= 1'b0;
    end else begin
      cyc.start <= 1'b0;
      if (cyc.done) awaiting <= 1'b0;
      if (state == NFH_IDLE && reg_wr_in && reg_addr_in == REG_CTRL) begin
        refused <= 1'b0;
        unique case (reg_wdata_in[2:0])
          // Gate on the protect bit that arrives with this very order;
          // the row last programmed waits for an erase first
          OP_PROGRAM: if (reg_wdata_in[31] && reg_wdata_in[14:3] != 12'h000
                          && !(last_vld && row == last_row)) begin
                        state    <= NFH_P_SETUP;
                        last_row <= row;
                        last_vld <= 1'b1;
                      end else refused <= 1'b1;
          OP_ERASE:   if (reg_wdata_in[31]) begin
                        state    <= NFH_E_SETUP;
                        last_vld <= 1'b0;
                      end else refused <= 1'b1;
          OP_RESET:   state <= NFH_RST_CMD;
          OP_STATUS:  state <= NFH_STAT_CMD;
          OP_SIG:     state <= NFH_SIG_CMD;
          default:    refused <= 1'b1;
        endcase
        idx <= 3'h0; loaded <= 12'h000;
      end else if (issue) begin
        awaiting <= 1'b1; cyc.start <= 1'b1;
        unique case (state)
          NFH_P_SETUP, NFH_E_SETUP, NFH_STAT_CMD, NFH_SIG_CMD,
          NFH_RST_CMD, NFH_P_CONF, NFH_E_CONF: cyc.kind <= NFH_CYC_CMD;
          NFH_P_ADDR, NFH_E_ADDR, NFH_SIG_ADDR, NFH_R_ADDR:
            cyc.kind <= NFH_CYC_ADDR;
          NFH_P_DATA: cyc.kind <= rand_req ? NFH_CYC_CMD : NFH_CYC_DATA;
          default: cyc.kind <= NFH_CYC_READ;
        endcase
        unique case (state)
          NFH_P_SETUP:  cyc.wdata <= CMD_PROG_SETUP;
          NFH_P_CONF:   cyc.wdata <= CMD_PROG_CONFIRM;
          NFH_E_SETUP:  cyc.wdata <= CMD_ERASE_SETUP;
          NFH_E_CONF:   cyc.wdata <= CMD_ERASE_CONF;
          NFH_RST_CMD:  cyc.wdata <= CMD_RESET;
          NFH_STAT_CMD: cyc.wdata <= CMD_STATUS;
          NFH_SIG_CMD:  cyc.wdata <= CMD_SIGNATURE;
          NFH_SIG_ADDR: cyc.wdata <= SIG_ADDR;
          NFH_P_ADDR:   cyc.wdata <= addr_byte(idx, column, row);
          NFH_E_ADDR:   cyc.wdata <= addr_byte(idx + 3'h2, column, row);
          NFH_R_ADDR:   cyc.wdata <= addr_byte(idx, rcolumn, row);
          NFH_P_DATA:   cyc.wdata <= rand_req ? CMD_RAND_INPUT : wbyte;
          default:      cyc.wdata <= ZERO8;
        endcase
        // Data load waits for a byte from software; that is the stall
        if (state == NFH_P_DATA && !rand_req && !wbyte_vld) begin
          awaiting <= 1'b0; cyc.start <= 1'b0;
        end
      end else if (cyc.done) begin
        unique case (state)
          NFH_P_SETUP: state <= NFH_P_ADDR;
          NFH_P_ADDR: if (idx == 3'(FULL_ADDR_CY - 1)) begin
            state <= NFH_P_DATA; idx <= 3'h0;
          end else idx <= idx + 3'h1;
          NFH_P_DATA: if (cyc.kind == NFH_CYC_CMD) state <= NFH_R_ADDR;
            else if (loaded == count) state <= NFH_P_CONF;
            // Row held for the whole load, so it stays in one block
            else loaded <= loaded + 12'h001;
          NFH_R_ADDR: if (idx == 3'(COL_ADDR_CY - 1)) begin
            state <= NFH_P_DATA; idx <= 3'h0;
          end else idx <= idx + 3'h1;
          NFH_E_SETUP: state <= NFH_E_ADDR;
          NFH_E_ADDR: if (idx == 3'(ROW_ADDR_CY - 1)) state <= NFH_E_CONF;
            else idx <= idx + 3'h1;
          NFH_P_CONF, NFH_E_CONF, NFH_RST_CMD: state <= NFH_WAIT_RB;
          // Status ends the operation; no page read is ever resumed
          NFH_STAT_CMD: state <= NFH_STAT_RD;
          NFH_STAT_RD: begin
            // Reserved bits masked so status is deterministic
            status <= {cyc.rdata[7:5], 4'h0, cyc.rdata[0]};
            state  <= NFH_IDLE;
          end
          NFH_SIG_CMD: state <= NFH_SIG_ADDR;
          NFH_SIG_ADDR: state <= NFH_SIG_RD;
          NFH_SIG_RD: begin
            sig <= {cyc.rdata, sig[31:8]};   // Byte 1 ends in bits 7:0
            if (idx == 3'(SIG_BYTES - 1)) state <= NFH_IDLE;
            else idx <= idx + 3'h1;
          end
          default: state <= state;
        endcase
      end else if (state == NFH_WAIT_RB && rb_s && !awaiting) begin
        // Ready again: fetch status to learn pass or fail
        state <= NFH_STAT_CMD;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      column <= 12'h000; row <= 18'h00000; count <= 12'h000;
      rcolumn <= 12'h000; wp_n <= 1'b0; wbyte <= 8'h00;
      wbyte_vld <= 1'b0; rand_req <= 1'b0;
    end else begin
      if (cyc.done && state == NFH_P_DATA) begin
        if (cyc.kind == NFH_CYC_CMD) rand_req <= 1'b0;
        else wbyte_vld <= 1'b0;
      end
      if (reg_wr_in) begin
        unique case (reg_addr_in)
          REG_CTRL: begin
            if (!busy && reg_wdata_in[2:0] == OP_PROGRAM) begin
              // Count field holds bytes; count keeps bytes minus one, capped at a page
              count <= (reg_wdata_in[14:3] > 12'(PAGE_MAX))
                       ? 12'(PAGE_MAX - 1) : reg_wdata_in[14:3] - 12'h001;
              wbyte_vld <= 1'b0;
            end
            if (state == NFH_P_DATA && reg_wdata_in[2:0] == OP_RANDIN)
              rand_req <= 1'b1;
            wp_n <= reg_wdata_in[31];
          end
          REG_COLUMN:  column  <= reg_wdata_in[11:0];
          REG_ROW:     row     <= reg_wdata_in[17:0];
          REG_RCOLUMN: rcolumn <= reg_wdata_in[11:0];
          REG_WDATA: begin
            wbyte <= reg_wdata_in[7:0]; wbyte_vld <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Read port: data stand in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) reg_rdata_out <= 32'h0;
    else if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CTRL:    reg_rdata_out <= {wp_n, 31'h0};
        REG_COLUMN:  reg_rdata_out <= {20'h0, column};
        REG_ROW:     reg_rdata_out <= {14'h0, row};
        REG_COUNT:   reg_rdata_out <= {20'h0, loaded};
        REG_STATE:   reg_rdata_out <= {24'h0, rb_s, wbyte_vld, refused,
                                       busy, state};
        REG_STATUS:  reg_rdata_out <= {24'h0, status};
        REG_SIG:     reg_rdata_out <= sig;
        REG_RCOLUMN: reg_rdata_out <= {20'h0, rcolumn};
        default:     reg_rdata_out <= 32'h0;
      endcase
    end else reg_rdata_out <= 32'h0;
  end

  sequence addr_done_s;
    state == NFH_P_ADDR && cyc.done && idx == 3'h4;
  endsequence
  prog_order_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    addr_done_s |=> state == NFH_P_DATA)
    else $error("Program did not enter data after five addresses");
  conf_code_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    cyc.start && state == NFH_P_CONF |-> cyc.wdata == 8'h10)
    else $error("Wrong program confirm code");
  erase_rows_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    state == NFH_E_CONF |-> idx == 3'h2)
    else $error("Erase confirm before three row cycles");
  protect_gate_a: assert property (@(posedge clk_sys_in) disable iff
    (!rst_n) $rose(state == NFH_P_SETUP || state == NFH_E_SETUP)
    |-> wp_n)
    else $error("Program or erase started while protected");
  wp_pin_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    ##1 flash_wp_n_out == $past(wp_n))
    else $error("Write protect pin does not follow register");
  rand_cols_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    state == NFH_R_ADDR |-> idx < 3'h2)
    else $error("Random input used more than two columns");
  status_res_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    status[4:1] == 4'h0)
    else $error("Reserved status bits not zero");
  sig_addr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    cyc.start && state == NFH_SIG_ADDR |-> cyc.wdata == 8'h00)
    else $error("Signature address not zero");
endmodule : nfh_host

// ### dv/nfh_flash_model.sv
/* Behavioural flash device facing the host sequencer on its pins.
   Assumes the bench resolves the shared data wire and feeds it back. */
`timescale 1ns/100ps
module nfh_flash_model #(
  parameter logic [31:0] SIG = 32'h5A16C3A5 // Arbitrary; byte 3 is 16h
) (
  input  wire logic [7:0] io_in,   // Data wire as seen
  input  wire logic       cle_in,  // Command latch select
  input  wire logic       ale_in,  // Address latch select
  input  wire logic       ce_n_in, // Chip select
  input  wire logic       we_n_in, // Write strobe
  input  wire logic       re_n_in, // Read strobe
  input  wire logic       wp_n_in, // Write protect, low protects
  input  wire logic       fail_in, // Make the next operation fail
  output logic      [7:0] io_out,  // Drive value while readable
  output logic            rb_out   // Ready/busy, high ready
);
  logic [7:0] cmd  = 8'hFF; // Last accepted command
  logic [7:0] stat = 8'hE0; // Status byte
  logic [7:0] junk = 8'h5A; // Released bus pattern
  logic [1:0] si   = 2'h0;  // Signature byte index
  logic       fl   = 1'b0;  // Failure latched at start
  int na = 0, nd = 0, nops = 0; // Address, data, operation counts
  int dsum = 0;                 // Sum of loaded data bytes
  event go;
  initial rb_out = 1'b1;
  // Released bus changes every cycle so stale values never pass
  always #100 junk = ~junk;
  // Bus writes latch on the write strobe rise
  always @(posedge we_n_in) if (!ce_n_in) begin
    if (!cle_in) begin
      if (ale_in) na++;
      else begin
        nd++;
        dsum += io_in;
      end
    end else if (rb_out || io_in == 8'h70 || io_in == 8'hFF) begin
      cmd = io_in;
      if (io_in == 8'h80 || io_in == 8'h60) begin
        na = 0;
        nd = 0;
        dsum = 0;
      end
      if (io_in == 8'h90) si = 2'h0;
      if (wp_n_in && (io_in == 8'hD0 || io_in == 8'h10 && nd > 0)) begin
        // Injected failure stands for bits that never reached zero
        fl = fail_in;
        ->go;
      end
      if (io_in == 8'hFF) begin
        fl = 1'b0;
        ->go;
      end
    end
  end
  // Busy period; a reset here is not expected by the bench
  always @(go) begin
    rb_out = 1'b0;
    stat = {wp_n_in, 7'h00};
    #2000;
    stat = {wp_n_in, 2'b11, 4'h0, fl};
    rb_out = 1'b1;
    nops++;
  end
  always @(posedge re_n_in) if (cmd == 8'h90) si++;
  // Status refreshes with no strobe toggle; program and erase setup leave it
  assign io_out = ce_n_in ? junk : cmd == 8'h90 ? SIG[8*si+:8] :
    (cmd == 8'h80 || cmd == 8'h60) ? junk : stat;
endmodule : nfh_flash_model

// ### dv/testbench.sv
/* Self-checking bench for the flash host sequencer.
   Assumes the flash model stands on the pins; wire resolved here. */
`timescale 1ns/100ps
module testbench;
  import nfh_pkg::*;
  logic        clk_sys_in = 1'b0, reset_n_in = 1'b0, fail = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;  // Register index
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, s;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0]  io_o, mdl_io;        // Host and device drive values
  logic        oe, cle, ale, ce_n, we_n, re_n, wp_n, rb;
  wire  [7:0]  io = oe ? io_o : mdl_io; // Resolved data wire
  int          miscompares = 0, compares = 0, cycles = 0, ops;
  always #50 clk_sys_in = ~clk_sys_in;
  nfh_host dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .flash_io_in(io), .flash_io_out(io_o),
    .flash_io_oe_out(oe), .command_latch_select_out(cle),
    .address_latch_select_out(ale), .flash_chip_sel_n_out(ce_n),
    .flash_wr_n_out(we_n), .flash_rd_n_out(re_n), .flash_wp_n_out(wp_n),
    .flash_rb_in(rb));
  nfh_flash_model flash (.io_in(io), .cle_in(cle), .ale_in(ale),
    .ce_n_in(ce_n), .we_n_in(we_n), .re_n_in(re_n), .wp_n_in(wp_n),
    .fail_in(fail), .io_out(mdl_io), .rb_out(rb));
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    v = reg_rdata_out;
  endtask : rd
  task automatic poll(input int b, input logic v);
    logic [31:0] t;
    for (int i = 0; i < 3000; i++) begin
      rd(REG_STATE, t);
      if (t[b] === v) return;
    end
    chk("state poll", v, ~v);
  endtask : poll
  task automatic prog(input int n, input logic wp, input logic f);
    logic [31:0] b;
    int          sum = 0;
    ops = flash.nops;
    fail <= f;
    wr(REG_COLUMN, $urandom_range(0, 2111));
    wr(REG_ROW, $urandom);
    wr(REG_CTRL, {wp, 16'h0, n[11:0], OP_PROGRAM});
    if (n == 0 || !wp) begin
      rd(REG_STATE, s);
      chk("refused", 1'b1, s[5]);
    end else begin
      for (int i = 0; i < n; i++) begin
        if (i == 1 && n > 2) begin
          wr(REG_RCOLUMN, $urandom_range(0, 2111));
          wr(REG_CTRL, {1'b1, 28'h0, OP_RANDIN});
        end
        b = $urandom;
        sum += b[7:0];
        wr(REG_WDATA, b);
        poll(6, 1'b0);
      end
      poll(4, 1'b0);
      chk("data bytes", n, flash.nd);
      chk("data sum", sum, flash.dsum);
      chk("addr", FULL_ADDR_CY + (n > 2 ? COL_ADDR_CY : 0), flash.na);
      rd(REG_STATUS, s);
      chk("status", {7'h70, f}, s[7:0]);
      rd(REG_COUNT, s);
      chk("loaded", n - 1, s);
      ops++;
    end
    chk("operations", ops, flash.nops);
    $display("test program of %0d bytes ended", n);
  endtask : prog
  task automatic erase(input logic f);
    fail <= f;
    wr(REG_ROW, $urandom);
    wr(REG_CTRL, {1'b1, 28'h0, OP_ERASE});
    poll(4, 1'b0);
    chk("erase addr", 3, flash.na);
    rd(REG_STATUS, s);
    chk("status", {7'h70, f}, s[7:0]);
    $display("test erase ended");
  endtask : erase
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Hang guard: the full run needs well under this many cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(64351));
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    wr(REG_CTRL, {1'b1, 28'h0, OP_SIG});
    poll(4, 1'b0);
    rd(REG_SIG, s);
    chk("signature", flash.SIG, s);
    $display("test signature ended");
    prog(1, 1'b1, 1'b0);
    wr(REG_CTRL, {1'b1, 16'h0, 12'h001, OP_PROGRAM});
    rd(REG_STATE, s);
    chk("page reuse", 1'b1, s[5]);
    prog(2112, 1'b1, 1'b0);
    prog(0, 1'b1, 1'b0);
    prog(3, 1'b0, 1'b0);
    prog(2, 1'b1, 1'b1);
    repeat (4) prog($urandom_range(1, 6), 1'b1, 1'($urandom_range(0, 1)));
    erase(1'b0);
    erase(1'b1);
    ops = flash.nops;
    wr(REG_CTRL, {1'b1, 28'h0, OP_RESET});
    poll(4, 1'b0);
    chk("reset busy", ops + 1, flash.nops);
    rd(REG_STATUS, s);
    chk("status", 8'hE0, s[7:0]);
    $display("test reset ended");
    finish_test();
  end
endmodule : testbench
